// ---- rtl/fprc_regs.vh ----
// constants for the floating-point register format classifier
`ifndef FPRC_REGS_VH
`define FPRC_REGS_VH

// ------------------------------------------------------------
// field layout of one 82-bit register value
// ------------------------------------------------------------
`define FPRC_WIDTH        82
`define FPRC_SIGN_BIT     81
`define FPRC_EXP_MSB      80
`define FPRC_EXP_LSB      64
`define FPRC_SIG_MSB      63
`define FPRC_INT_BIT      63
`define FPRC_FRAC_TOP     62

// ------------------------------------------------------------
// exponent encodings
// ------------------------------------------------------------
`define FPRC_EXP_BIAS     17'h0_FFFF
`define FPRC_EXP_ONES     17'h1_FFFF
`define FPRC_EXP_TOKEN    17'h1_FFFE
`define FPRC_EXP_INT      17'h1_003E
`define FPRC_EXP_ONE      17'h0_FFFF
`define FPRC_EXP_MINREG   17'h0_0001
`define FPRC_EXP_DENXE    18'h3_C002
`define FPRC_SNG_MIN      17'h0_FF81
`define FPRC_SNG_MAX      17'h1_007E
`define FPRC_DBL_MIN      17'h0_FC01
`define FPRC_DBL_MAX      17'h1_03FE
`define FPRC_EXT_MIN      17'h0_C001
`define FPRC_EXT_MAX      17'h1_3FFE
`define FPRC_REG_MAX      17'h1_FFFE

// ------------------------------------------------------------
// significand constants
// ------------------------------------------------------------
`define FPRC_SIG_ONE      64'h8000_0000_0000_0000
`define FPRC_SIG_QNAN     64'hC000_0000_0000_0000
`define FPRC_SNG_LOWMASK  64'h0000_00FF_FFFF_FFFF
`define FPRC_DBL_LOWMASK  64'h0000_0000_0000_07FF

// ------------------------------------------------------------
// classes
// ------------------------------------------------------------
`define FPRC_CL_ZERO      4'h0
`define FPRC_CL_NORMAL    4'h1
`define FPRC_CL_UNNORMAL  4'h2
`define FPRC_CL_XDENORM   4'h3
`define FPRC_CL_PSDENORM  4'h4
`define FPRC_CL_PSZERO    4'h5
`define FPRC_CL_INF       4'h6
`define FPRC_CL_QNAN      4'h7
`define FPRC_CL_SNAN      4'h8
`define FPRC_CL_PSNAN     4'h9
`define FPRC_CL_PSINF     4'hA
`define FPRC_CL_TOKEN     4'hB

// ------------------------------------------------------------
// operation kinds and destination types
// ------------------------------------------------------------
`define FPRC_OP_ADD       2'h0
`define FPRC_OP_MUL       2'h1
`define FPRC_OP_INT       2'h2
`define FPRC_DST_SNG      2'h0
`define FPRC_DST_DBL      2'h1
`define FPRC_DST_EXT      2'h2
`define FPRC_DST_REG      2'h3

`endif

// ---- rtl/fprc_class_decode.v ----
// class decode of one register value
`timescale 1ns/10ps
`include "fprc_regs.vh"

module fprc_class_decode (
  input  wire [81:0] value,
  output reg  [3:0]  valClass,
  output wire        isNeg,
  output wire [17:0] effExp,
  output wire        isIntCanon,
  output wire        isSngNormal,
  output wire        isDblNormal,
  output wire        isExtNormal
);

  wire        sign     = value[`FPRC_SIGN_BIT];
  wire [16:0] exp      = value[`FPRC_EXP_MSB:`FPRC_EXP_LSB];
  wire [63:0] sig      = value[`FPRC_SIG_MSB:0];
  wire        intBit   = sig[`FPRC_INT_BIT];
  wire        fracZero = (sig[62:0] == 63'h0);
  wire        expOnes  = (exp == `FPRC_EXP_ONES);
  wire        expZero  = (exp == 17'h0_0000);
  wire        sigZero  = (sig == 64'h0);

  assign isNeg = sign; // RULE6
  // zero exponent uses a fixed scale equal to biased 0x0C001
  assign effExp = expZero ? (`FPRC_EXP_DENXE) :
                  ({1'b0, exp} - {1'b0, `FPRC_EXP_BIAS}); // RULE2 RULE7 RULE8
  assign isIntCanon = !sign && (exp == `FPRC_EXP_INT); // RULE9

  // -------------------------------------------------------
  // specials checked first so overlapping ranges lose
  // -------------------------------------------------------
  always @* begin
    if (expOnes) begin // RULE3 RULE24
      if (intBit) begin
        if (fracZero)
          valClass = `FPRC_CL_INF; // RULE13
        else if (sig[`FPRC_FRAC_TOP])
          valClass = `FPRC_CL_QNAN; // RULE13
        else
          valClass = `FPRC_CL_SNAN; // RULE13
      end else begin
        valClass = fracZero ? `FPRC_CL_PSINF : `FPRC_CL_PSNAN; // RULE14
      end
    end else if (expZero) begin
      if (sigZero)
        valClass = `FPRC_CL_ZERO; // RULE4
      else
        valClass = intBit ? `FPRC_CL_PSDENORM : `FPRC_CL_XDENORM; // RULE5
    end else if (sigZero) begin
      if (!sign && exp == `FPRC_EXP_TOKEN)
        valClass = `FPRC_CL_TOKEN; // RULE15
      else
        valClass = `FPRC_CL_PSZERO; // RULE16
    end else begin
      valClass = intBit ? `FPRC_CL_NORMAL : `FPRC_CL_UNNORMAL;
    end
  end

  wire normal = (valClass == `FPRC_CL_NORMAL);
  assign isSngNormal = normal && exp >= `FPRC_SNG_MIN && exp <= `FPRC_SNG_MAX &&
                       ((sig & `FPRC_SNG_LOWMASK) == 64'h0); // RULE22
  assign isDblNormal = normal && exp >= `FPRC_DBL_MIN && exp <= `FPRC_DBL_MAX &&
                       ((sig & `FPRC_DBL_LOWMASK) == 64'h0); // RULE22
  assign isExtNormal = normal && exp >= `FPRC_EXT_MIN && exp <= `FPRC_EXT_MAX; // RULE22

endmodule // fprc_class_decode

// ---- rtl/fprc_classifier.v ----
// register format classifier and result canonicaliser
// What this block does
// RULE1 - 82 bits: sign, 17-bit exponent, 64-bit significand
// RULE2 - exponent bias is 65535
// RULE3 - all-ones exponent: infinities and NaNs
// RULE4 - zero exponent and significand: signed zero
// RULE5 - zero exponent, non-zero significand: denormal or pseudo-denormal
// RULE6 - sign zero positive, one negative
// RULE7 - non-zero exponent scales by two to exponent minus bias
// RULE8 - zero exponent scales by two to minus 16382
// RULE9 - canonical integers: exponent 0x1003E, sign zero
// RULE10 - register zero reads +0, register one reads +1
// RULE11 - constant one unchanged for parallel and integer operations
// RULE12 - masked invalid yields negative quiet NaN indefinite
// RULE13 - all-ones exponent, integer bit: infinity, QNaN or SNaN
// RULE14 - all-ones exponent, no integer bit: pseudo-NaN or pseudo-infinity
// RULE15 - deferred-exception token is its own class
// RULE16 - zero significand, mid exponent: pseudo-zero, an unnormal
// RULE17 - pseudo-zero acts as zero; times infinity gives signed infinity
// RULE18 - every encoding accepted as operand
// RULE19 - results most normalized, clamped to destination, canonical specials
// RULE20 - extended denormal results use exponent zero, not 0x0C001
// RULE21 - arithmetic never produces pseudo encodings
// RULE22 - per-precision normal exponent ranges
// RULE23 - unnormal flag sticky, set only by real participation
// RULE24 - one class per encoding; specials win
`timescale 1ns/10ps
`include "fprc_regs.vh"

module fprc_classifier (
  input  wire        sys_clk,
  input  wire        rst_b,
  // operand request
  input  wire        opValid,
  input  wire [1:0]  opKind,
  input  wire [6:0]  opAIdx,
  input  wire [81:0] opAData,
  input  wire [6:0]  opBIdx,
  input  wire [81:0] opBData,
  // operand answer
  output reg         outValid,
  output reg  [81:0] opAValue,
  output reg  [81:0] opBValue,
  output reg  [3:0]  opAClass,
  output reg  [3:0]  opBClass,
  output reg  [17:0] opAEffExp,
  output reg  [17:0] opBEffExp,
  output reg  [1:0]  opAIntPrec,
  output reg  [1:0]  opBIntPrec,
  output reg  [2:0]  opAPrecNormal,
  output reg  [2:0]  opBPrecNormal,
  output reg         specialValid,
  output reg  [81:0] specialResult,
  output reg         invalidOp,
  output reg         unnormFlag,
  input  wire        unnormFlagClear,
  // raw result to write back
  input  wire        resValid,
  input  wire [1:0]  resDest,
  input  wire        resSign,
  input  wire [16:0] resExp,
  input  wire [63:0] resSig,
  output reg         wbValid,
  output reg  [81:0] wbValue
);

  // -------------------------------------------------------
  // constant registers
  // -------------------------------------------------------
  localparam [81:0] CONST_ZERO = {1'b0, 17'h0_0000, 64'h0};
  localparam [81:0] CONST_ONE  = {1'b0, `FPRC_EXP_ONE, `FPRC_SIG_ONE};
  localparam [81:0] QNAN_INDEF = {1'b1, `FPRC_EXP_ONES, `FPRC_SIG_QNAN};
  localparam [81:0] TOKEN_VAL  = {1'b0, `FPRC_EXP_TOKEN, 64'h0};

  // constants substituted for every operation kind
  wire [81:0] valA = (opAIdx == 7'h00) ? CONST_ZERO :
                     (opAIdx == 7'h01) ? CONST_ONE : opAData; // RULE10 RULE11
  wire [81:0] valB = (opBIdx == 7'h00) ? CONST_ZERO :
                     (opBIdx == 7'h01) ? CONST_ONE : opBData; // RULE10 RULE11

  // -------------------------------------------------------
  // operand decode
  // -------------------------------------------------------
  wire [3:0]  clA;
  wire [3:0]  clB;
  wire        negA;
  wire        negB;
  wire [17:0] effA;
  wire [17:0] effB;
  wire        intA;
  wire        intB;
  wire [2:0]  precA;
  wire [2:0]  precB;

  fprc_class_decode decA (
    .value       (valA),
    .valClass    (clA),
    .isNeg       (negA),
    .effExp      (effA),
    .isIntCanon  (intA),
    .isSngNormal (precA[0]),
    .isDblNormal (precA[1]),
    .isExtNormal (precA[2])
  );

  fprc_class_decode decB (
    .value       (valB),
    .valClass    (clB),
    .isNeg       (negB),
    .effExp      (effB),
    .isIntCanon  (intB),
    .isSngNormal (precB[0]),
    .isDblNormal (precB[1]),
    .isExtNormal (precB[2])
  );

  wire nanA   = (clA == `FPRC_CL_QNAN) || (clA == `FPRC_CL_SNAN);
  wire nanB   = (clB == `FPRC_CL_QNAN) || (clB == `FPRC_CL_SNAN);
  wire snanA  = (clA == `FPRC_CL_SNAN);
  wire snanB  = (clB == `FPRC_CL_SNAN);
  wire psA    = (clA == `FPRC_CL_PSNAN) || (clA == `FPRC_CL_PSINF);
  wire psB    = (clB == `FPRC_CL_PSNAN) || (clB == `FPRC_CL_PSINF);
  wire tokA   = (clA == `FPRC_CL_TOKEN);
  wire tokB   = (clB == `FPRC_CL_TOKEN);
  wire infA   = (clA == `FPRC_CL_INF);
  wire infB   = (clB == `FPRC_CL_INF);
  wire pzA    = (clA == `FPRC_CL_PSZERO);
  wire pzB    = (clB == `FPRC_CL_PSZERO);
  wire zeroA  = (clA == `FPRC_CL_ZERO) || pzA; // RULE17
  wire zeroB  = (clB == `FPRC_CL_ZERO) || pzB; // RULE17
  wire unA    = (clA == `FPRC_CL_UNNORMAL) || (clA == `FPRC_CL_XDENORM) ||
                (clA == `FPRC_CL_PSDENORM) || pzA;
  wire unB    = (clB == `FPRC_CL_UNNORMAL) || (clB == `FPRC_CL_XDENORM) ||
                (clB == `FPRC_CL_PSDENORM) || pzB;
  wire arith  = (opKind == `FPRC_OP_ADD) || (opKind == `FPRC_OP_MUL);

  // -------------------------------------------------------
  // special results; every encoding is accepted as input
  // -------------------------------------------------------
  reg        spcValid;
  reg [81:0] spcValue;
  reg        spcInvalid;
  reg        spcNoCalc;

  always @* begin // RULE18
    spcValid   = 1'b0;
    spcValue   = CONST_ZERO;
    spcInvalid = 1'b0;
    spcNoCalc  = 1'b0;
    if (!arith) begin
      spcValid = 1'b0;
    end else if (tokA || tokB) begin
      spcValid  = 1'b1;
      spcValue  = TOKEN_VAL; // RULE15
      spcNoCalc = 1'b1;
    end else if (psA || psB) begin
      spcValid   = 1'b1;
      spcValue   = QNAN_INDEF; // RULE12 RULE21
      spcInvalid = 1'b1;
      spcNoCalc  = 1'b1;
    end else if (nanA || nanB) begin
      // first NaN wins, quieted
      spcValid   = 1'b1;
      spcValue   = nanA ? valA : valB;
      spcValue[`FPRC_FRAC_TOP] = 1'b1;
      spcInvalid = snanA || snanB;
      spcNoCalc  = 1'b1;
    end else if (opKind == `FPRC_OP_MUL && ((infA && zeroB) || (infB && zeroA))) begin
      spcValid = 1'b1;
      if ((infA && pzB) || (infB && pzA)) begin
        spcValue = {negA ^ negB, `FPRC_EXP_ONES, `FPRC_SIG_ONE}; // RULE17
      end else begin
        spcValue   = QNAN_INDEF; // RULE12
        spcInvalid = 1'b1;
      end
    end else if (opKind == `FPRC_OP_ADD && infA && infB && (negA != negB)) begin
      spcValid   = 1'b1;
      spcValue   = QNAN_INDEF; // RULE12
      spcInvalid = 1'b1;
    end else if (infA || infB) begin
      spcValid = 1'b1;
      if (opKind == `FPRC_OP_MUL)
        spcValue = {negA ^ negB, `FPRC_EXP_ONES, `FPRC_SIG_ONE}; // RULE19
      else
        spcValue = {infA ? negA : negB, `FPRC_EXP_ONES, `FPRC_SIG_ONE}; // RULE19
    end
  end

  // only operands that reach the calculation set the flag
  wire unnormSet = opValid && arith && !spcNoCalc && !spcInvalid && (unA || unB); // RULE23

  // -------------------------------------------------------
  // operand answer register
  // -------------------------------------------------------
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      outValid      <= 1'b0;
      opAValue      <= 82'h0;
      opBValue      <= 82'h0;
      opAClass      <= `FPRC_CL_ZERO;
      opBClass      <= `FPRC_CL_ZERO;
      opAEffExp     <= 18'h0_0000;
      opBEffExp     <= 18'h0_0000;
      opAIntPrec    <= 2'h0;
      opBIntPrec    <= 2'h0;
      opAPrecNormal <= 3'h0;
      opBPrecNormal <= 3'h0;
      specialValid  <= 1'b0;
      specialResult <= 82'h0;
      invalidOp     <= 1'b0;
    end else begin
      outValid      <= opValid;
      opAValue      <= valA; // RULE1
      opBValue      <= valB; // RULE1
      opAClass      <= clA; // RULE24
      opBClass      <= clB; // RULE24
      opAEffExp     <= effA;
      opBEffExp     <= effB;
      opAIntPrec    <= {intA, negA};
      opBIntPrec    <= {intB, negB};
      opAPrecNormal <= precA;
      opBPrecNormal <= precB;
      specialValid  <= opValid && spcValid;
      specialResult <= spcValue;
      invalidOp     <= opValid && spcInvalid;
    end
  end

  // set wins over a same-cycle clear
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      unnormFlag <= 1'b0;
    end else if (unnormSet) begin
      unnormFlag <= 1'b1; // RULE23
    end else if (unnormFlagClear) begin
      unnormFlag <= 1'b0;
    end
  end

  // -------------------------------------------------------
  // result canonicaliser
  // -------------------------------------------------------
  function [6:0] lead_zeros;
    input [63:0] s;
    integer i;
    reg     found;
    begin
      lead_zeros = 7'd64;
      found = 1'b0;
      for (i = 63; i >= 0; i = i - 1) begin
        if (!found && s[i]) begin
          lead_zeros = 7'd63 - i[6:0];
          found = 1'b1;
        end
      end
    end
  endfunction

  reg [16:0] dstMin;
  reg [16:0] dstMax;
  reg [63:0] dstMask;

  always @* begin
    case (resDest)
      `FPRC_DST_SNG: begin
        dstMin  = `FPRC_SNG_MIN;
        dstMax  = `FPRC_SNG_MAX;
        dstMask = ~`FPRC_SNG_LOWMASK;
      end
      `FPRC_DST_DBL: begin
        dstMin  = `FPRC_DBL_MIN;
        dstMax  = `FPRC_DBL_MAX;
        dstMask = ~`FPRC_DBL_LOWMASK;
      end
      `FPRC_DST_EXT: begin
        dstMin  = `FPRC_EXT_MIN;
        dstMax  = `FPRC_EXT_MAX;
        dstMask = 64'hFFFF_FFFF_FFFF_FFFF;
      end
      default: begin
        dstMin  = `FPRC_EXP_MINREG;
        dstMax  = `FPRC_REG_MAX;
        dstMask = 64'hFFFF_FFFF_FFFF_FFFF;
      end
    endcase
  end

  // exponent zero scales like 0x0C001
  wire [16:0] inExp   = (resExp == 17'h0_0000) ? `FPRC_EXT_MIN : resExp;
  wire [6:0]  lz      = lead_zeros(resSig);
  wire [16:0] room    = (inExp > dstMin) ? (inExp - dstMin) : 17'h0_0000;
  wire [16:0] shamt   = ({10'h000, lz} < room) ? {10'h000, lz} : room;
  wire [63:0] normSig = (resSig << shamt[6:0]) & dstMask; // RULE19
  wire [16:0] normExp = inExp - shamt;
  reg  [81:0] wbNext;

  always @* begin
    if (resExp == `FPRC_EXP_ONES) begin
      if (resSig[62:0] == 63'h0)
        wbNext = {resSign, `FPRC_EXP_ONES, `FPRC_SIG_ONE}; // RULE19 RULE21
      else
        wbNext = {resSign, `FPRC_EXP_ONES, resSig | `FPRC_SIG_QNAN}; // RULE21
    end else if (normSig == 64'h0) begin
      wbNext = {resSign, 17'h0_0000, 64'h0}; // RULE19 RULE21
    end else if (normExp > dstMax) begin
      // overflow gives signed infinity; rounding is done outside
      wbNext = {resSign, `FPRC_EXP_ONES, `FPRC_SIG_ONE}; // RULE19
    end else if (!normSig[`FPRC_INT_BIT] && normExp == `FPRC_EXT_MIN) begin
      wbNext = {resSign, 17'h0_0000, normSig}; // RULE20
    end else begin
      wbNext = {resSign, normExp, normSig}; // RULE19
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wbValid <= 1'b0;
      wbValue <= 82'h0;
    end else begin
      wbValid <= resValid;
      wbValue <= wbNext;
    end
  end

endmodule // fprc_classifier

// ---- verif/fprc_regfile_model.sv ----
// register file stand-in that feeds operand data by index
`timescale 1ns/10ps

module fprc_regfile_model (
  input  wire        sys_clk,
  input  wire        wrEn,
  input  wire [6:0]  wrIdx,
  input  wire [81:0] wrData,
  input  wire [6:0]  rdAIdx,
  input  wire [6:0]  rdBIdx,
  output wire [81:0] rdAData,
  output wire [81:0] rdBData
);
  reg [81:0] mem [0:127];

  // no write-through
  always @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
  end
  assign rdAData = mem[rdAIdx];
  assign rdBData = mem[rdBIdx];
endmodule // fprc_regfile_model

// ---- verif/fprc_classifier_chk.sv ----
// port assertions for the classifier
`timescale 1ns/10ps
`include "fprc_regs.vh"

module fprc_classifier_chk (
  input wire        sys_clk,
  input wire        rst_b,
  input wire        opValid,
  input wire [1:0]  opKind,
  input wire [6:0]  opAIdx,
  input wire [81:0] opAData,
  input wire [6:0]  opBIdx,
  input wire [81:0] opBData,
  input wire        outValid,
  input wire [81:0] opAValue,
  input wire [3:0]  opBClass,
  input wire [17:0] opBEffExp,
  input wire        specialValid,
  input wire [81:0] specialResult,
  input wire        invalidOp,
  input wire        unnormFlag,
  input wire        unnormFlagClear,
  input wire        resValid,
  input wire [1:0]  resDest,
  input wire        wbValid,
  input wire [81:0] wbValue
);
  wire [16:0] bExp    = opBData[80:64];
  wire [16:0] wExp    = wbValue[80:64];
  wire        bReg    = opValid && opBIdx > 7'h01;
  wire        bFracNz = opBData[62:0] != 63'h0;
  wire        sgnX    = opAData[81] ^ opBData[81];
  // a NaN operand beside no pseudo-NaN or pseudo-infinity makes invalid return it quieted, not the indefinite
  wire        aNan    = opAIdx > 7'h01 && opAData[80:63] == 18'h3_FFFF && opAData[62:0] != 63'h0;
  wire        bNan    = bReg && opBData[80:63] == 18'h3_FFFF && bFracNz;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ---------------------------------------------------------
  // sequences
  // ---------------------------------------------------------
  sequence s_infTimesPz;
    opValid && opKind == `FPRC_OP_MUL && opAIdx > 7'h01
      && opAData[80:0] == {`FPRC_EXP_ONES, `FPRC_SIG_ONE}
      && bReg && opBData[63:0] == 64'h0 && bExp != 17'h0 && bExp <= 17'h1_FFFD;
  endsequence
  sequence s_signedInf;
    specialValid && !invalidOp
      && specialResult == {$past(sgnX), `FPRC_EXP_ONES, `FPRC_SIG_ONE};
  endsequence
  sequence s_resExt;
    resValid && resDest == `FPRC_DST_EXT;
  endsequence

  // ---------------------------------------------------------
  // operand path
  // ---------------------------------------------------------
  a_answer_follows: assert property (opValid |=> outValid)
    else $error("operand answer missing");
  a_const_zero: assert property (opValid && opAIdx == 7'h00 |=> opAValue == 82'h0)
    else $error("constant zero wrong");
  a_const_one: assert property (opValid && opAIdx == 7'h01
    |=> opAValue == {1'b0, `FPRC_EXP_ONE, `FPRC_SIG_ONE})
    else $error("constant one wrong");
  a_zero_class: assert property (bReg && opBData[80:0] == 81'h0
    |=> opBClass == `FPRC_CL_ZERO)
    else $error("zero class wrong");
  a_token_class: assert property (bReg && opBData == {1'b0, `FPRC_EXP_TOKEN, 64'h0}
    |=> opBClass == `FPRC_CL_TOKEN)
    else $error("token class wrong");
  a_pseudo_class: assert property (bReg && bExp == `FPRC_EXP_ONES && !opBData[63]
    |=> opBClass == ($past(bFracNz) ? `FPRC_CL_PSNAN : `FPRC_CL_PSINF))
    else $error("pseudo class wrong");
  a_eff_exp: assert property (bReg && bExp != 17'h0
    |=> opBEffExp == {1'b0, $past(bExp)} - 18'h0_FFFF)
    else $error("exponent bias wrong");
  a_den_exp: assert property (bReg && bExp == 17'h0 |=> opBEffExp == `FPRC_EXP_DENXE)
    else $error("zero exponent scale wrong");
  a_pz_inf: assert property (s_infTimesPz |=> s_signedInf)
    else $error("pseudo-zero times infinity wrong");
  a_indef_value: assert property (invalidOp && !$past(aNan || bNan)
    |-> specialValid && specialResult == {1'b1, `FPRC_EXP_ONES, `FPRC_SIG_QNAN})
    else $error("indefinite wrong");
  a_flag_sticky: assert property (unnormFlag && !unnormFlagClear |=> unnormFlag)
    else $error("flag lost");
  a_flag_intop: assert property (opValid && opKind[1] && !unnormFlag
    |=> !unnormFlag)
    else $error("flag set by integer operation");

  // ---------------------------------------------------------
  // result path
  // ---------------------------------------------------------
  a_den_zexp: assert property (s_resExt
    |=> wbValid && !(wExp == `FPRC_EXT_MIN && !wbValue[63]))
    else $error("denormal result exponent wrong");
  a_no_pseudo: assert property (wbValid |-> !(wExp == `FPRC_EXP_ONES && !wbValue[63])
    && !(wExp == 17'h0 && wbValue[63]) && !(wbValue[63:0] == 64'h0 && wExp != 17'h0
    && wbValue[81:64] != {1'b0, `FPRC_EXP_TOKEN}))
    else $error("pseudo encoding produced");
endmodule // fprc_classifier_chk

bind fprc_classifier fprc_classifier_chk u_chk (.*);

// ---- verif/fprc_classifier_tb_top.sv ----
// self-checking bench for the classifier
`timescale 1ns/10ps
`include "fprc_regs.vh"

module fprc_classifier_tb_top;
  typedef struct packed {
    logic [81:0] av;
    logic [3:0]  bc;
    logic        sv;
    logic [81:0] sr;
    logic        inv;
    logic        fl;
  } fprc_opx_t;
  localparam logic [81:0] QIND = {1'b1, `FPRC_EXP_ONES, `FPRC_SIG_QNAN};
  localparam logic [81:0] PINF = {1'b0, `FPRC_EXP_ONES, `FPRC_SIG_ONE};
  reg          sys_clk = 1'b0, rst_b = 1'b0, opValid = 1'b0, unnormFlagClear = 1'b0;
  reg          resValid = 1'b0, resSign = 1'b0, wrEn = 1'b0, expFlag = 1'b0;
  reg   [1:0]  opKind = 2'h0, resDest = 2'h0;
  reg   [6:0]  opAIdx = 7'h00, opBIdx = 7'h00, wrIdx = 7'h00;
  reg   [16:0] resExp = 17'h0;
  reg   [63:0] resSig = 64'h0;
  reg   [81:0] wrData = 82'h0, v, wbq [$], tv [$];
  wire  [81:0] opAData, opBData, opAValue, specialResult, wbValue;
  wire  [3:0]  opBClass;
  wire         outValid, specialValid, invalidOp, unnormFlag, wbValid;
  int          mismatches = 0, nChecks = 0, cycles = 0, i;
  fprc_opx_t   got, opq [$];
  reg   [3:0]  tc [$];

  always #12.5 sys_clk = ~sys_clk;

  fprc_regfile_model u_rf (.sys_clk, .wrEn, .wrIdx, .wrData,
    .rdAIdx(opAIdx), .rdBIdx(opBIdx), .rdAData(opAData), .rdBData(opBData));

  fprc_classifier DUT (.sys_clk, .rst_b, .opValid, .opKind, .opAIdx, .opAData, .opBIdx,
    .opBData, .outValid, .opAValue, .opBValue(), .opAClass(), .opBClass, .opAEffExp(),
    .opBEffExp(), .opAIntPrec(), .opBIntPrec(), .opAPrecNormal(), .opBPrecNormal(),
    .specialValid, .specialResult, .invalidOp, .unnormFlag, .unnormFlagClear, .resValid,
    .resDest, .resSign, .resExp, .resSig, .wbValid, .wbValue);

  // ---------------------------------------------------------
  // tasks
  // ---------------------------------------------------------
  task automatic cmp(input string n, input logic [81:0] ex, s);
    nChecks++;
    if (s !== ex) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, ex, s);
    end
  endtask

  task automatic stopTest;
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic add(input logic [81:0] x, input logic [3:0] c);
    tv.push_back(x);
    tc.push_back(c);
  endtask

  // operand indexes above one name table entry (index minus two)
  task automatic op(input logic [1:0] k, input logic [6:0] a, b,
                    input logic sv, input logic [81:0] sr, input logic inv, input logic uf);
    fprc_opx_t x;
    @(posedge sys_clk);
    opValid <= 1'b1;
    opKind <= k;
    opAIdx <= a;
    opBIdx <= b;
    expFlag = expFlag | uf;
    x.av = a == 7'h00 ? 82'h0 : a == 7'h01 ? 82'hFFFF_8000_0000_0000_0000 : tv[a - 2];
    x.bc = b == 7'h00 ? `FPRC_CL_ZERO : b == 7'h01 ? `FPRC_CL_NORMAL : tc[b - 2];
    x.sv = sv;
    x.sr = sr;
    x.inv = inv;
    x.fl = expFlag;
    opq.push_back(x);
  endtask

  task automatic res(input logic [1:0] d, input logic s, input logic [16:0] x,
                     input logic [63:0] g, input logic [81:0] ex);
    @(posedge sys_clk);
    resValid <= 1'b1;
    resDest <= d;
    resSign <= s;
    resExp <= x;
    resSig <= g;
    wbq.push_back(ex);
  endtask

  task automatic idle;
    @(posedge sys_clk);
    opValid <= 1'b0;
    resValid <= 1'b0;
  endtask

  // ---------------------------------------------------------
  // monitor and watchdog
  // ---------------------------------------------------------
  always @(negedge sys_clk) begin
    if (outValid === 1'b1) begin
      got = opq.size() > 0 ? opq.pop_front() : '1;
      cmp("opAValue", got.av, opAValue);
      cmp("opBClass", got.bc, opBClass);
      cmp("specialValid", got.sv, specialValid);
      if (got.sv) cmp("specialResult", got.sr, specialResult);
      cmp("invalidOp", got.inv, invalidOp);
      cmp("unnormFlag", got.fl, unnormFlag);
    end
    if (wbValid === 1'b1) cmp("wbValue", wbq.size() > 0 ? wbq.pop_front() : '1, wbValue);
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      stopTest();
    end
  end

  // ---------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------
  initial begin
    void'($urandom(32'heae9_d4f2));
    add(82'h0, `FPRC_CL_ZERO);
    add({1'b1, 81'h0}, `FPRC_CL_ZERO);
    add(82'h1, `FPRC_CL_XDENORM);
    add({1'b1, 81'h8000_0000_0000_0001}, `FPRC_CL_PSDENORM);
    add(PINF, `FPRC_CL_INF);
    add(QIND, `FPRC_CL_QNAN);
    add({1'b0, `FPRC_EXP_ONES, 64'h8000_0000_0000_0001}, `FPRC_CL_SNAN);
    add({1'b0, `FPRC_EXP_ONES, 64'h1}, `FPRC_CL_PSNAN);
    add({1'b1, `FPRC_EXP_ONES, 64'h0}, `FPRC_CL_PSINF);
    add({1'b0, `FPRC_EXP_TOKEN, 64'h0}, `FPRC_CL_TOKEN);
    add({1'b1, `FPRC_EXP_TOKEN, 64'h0}, `FPRC_CL_PSZERO);
    add({1'b0, 17'h0_0001, 64'h0}, `FPRC_CL_PSZERO);
    add({1'b0, 17'h1_FFFD, 64'h0}, `FPRC_CL_PSZERO);
    add(82'hFFFF_8000_0000_0000_0000, `FPRC_CL_NORMAL);
    add({1'b0, 17'h0_FFFF, 64'h4000_0000_0000_0000}, `FPRC_CL_UNNORMAL);
    add({1'b0, `FPRC_EXP_TOKEN, `FPRC_SIG_ONE}, `FPRC_CL_NORMAL);
    v = {1'b0, 17'h0_0001 + 17'($urandom % 131070), 1'b1, 63'({$urandom, $urandom})};
    add(v, `FPRC_CL_NORMAL);
    v[63] = 1'b0;
    v[0] = 1'b1;
    add(v, `FPRC_CL_UNNORMAL);
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    // junk in entries 0 and 1 exposes substitution
    for (i = 0; i < tv.size() + 2; i++) begin
      @(posedge sys_clk);
      wrEn <= 1'b1;
      wrIdx <= 7'(i);
      wrData <= i < 2 ? QIND : tv[i - 2];
    end
    @(posedge sys_clk);
    wrEn <= 1'b0;
    for (i = 0; i < tc.size(); i++)
      op(2'h2 + 2'(i % 2), i % 3 == 2 ? 7'(2 + $urandom % tv.size()) : 7'(i % 3),
         7'(i + 2), 0, 82'h0, 0, 0);
    op(`FPRC_OP_MUL, 7'h06, 7'h02, 1, QIND, 1, 0);
    op(`FPRC_OP_ADD, 7'h09, 7'h0F, 1, QIND, 1, 0);
    op(`FPRC_OP_ADD, 7'h0B, 7'h0F, 1, {1'b0, `FPRC_EXP_TOKEN, 64'h0}, 0, 0);
    op(`FPRC_OP_MUL, 7'h10, 7'h08, 1, {1'b0, `FPRC_EXP_ONES, 64'hC000_0000_0000_0001}, 1, 0);
    op(`FPRC_OP_ADD, 7'h07, 7'h0F, 1, QIND, 0, 0);
    op(`FPRC_OP_ADD, 7'h0F, 7'h10, 0, 82'h0, 0, 1);
    op(`FPRC_OP_MUL, 7'h06, 7'h0C, 1, {1'b1, `FPRC_EXP_ONES, `FPRC_SIG_ONE}, 0, 1);
    @(posedge sys_clk);
    opValid <= 1'b0;
    unnormFlagClear <= 1'b1;
    expFlag = 1'b0;
    @(posedge sys_clk);
    unnormFlagClear <= 1'b0;
    op(`FPRC_OP_MUL, 7'h12, 7'h01, 0, 82'h0, 0, 0);
    idle();
    res(`FPRC_DST_EXT, 0, 17'h0_C005, 64'h0400_0000_0000_0000,
        82'h4000_0000_0000_0000);
    res(`FPRC_DST_REG, 1, 17'h1_2345, 64'h0, {1'b1, 81'h0});
    res(`FPRC_DST_REG, 0, `FPRC_EXP_ONES, 64'h0, PINF);
    res(`FPRC_DST_REG, 1, `FPRC_EXP_ONES, 64'h1,
        {1'b1, `FPRC_EXP_ONES, 64'hC000_0000_0000_0001});
    res(`FPRC_DST_SNG, 0, 17'h1_0000, '1, 82'h1_0000_FFFF_FF00_0000_0000);
    res(`FPRC_DST_DBL, 0, 17'h1_0000, '1, 82'h1_0000_FFFF_FFFF_FFFF_F800);
    res(`FPRC_DST_DBL, 0, 17'h1_0400, `FPRC_SIG_ONE, PINF);
    res(`FPRC_DST_REG, 0, 17'h1_0000, 64'h1, 82'hFFC1_8000_0000_0000_0000);
    repeat (4) begin
      v = {1'b0, 17'h0_0001 + 17'($urandom % 131070), 1'b1, 63'({$urandom, $urandom})};
      res(`FPRC_DST_REG, v[81], v[80:64], v[63:0], v);
    end
    idle();
    repeat (3) @(posedge sys_clk);
    cmp("pending", 82'h0, 82'(opq.size() + wbq.size()));
    stopTest();
  end
endmodule // fprc_classifier_tb_top
